// file: fer_chk_sva.sv
// Checker of explicit status timing and of the cyclic mode error flag
`timescale 1ns/10ps
module fer_chk
  import fer_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RESETN,
  input wire logic       EXP_REQ_VALID,
  input wire logic       EXP_PATH_SEG_BAD,
  input wire logic       EXP_PATH_UNKNOWN,
  input wire logic       EXP_RSP_VALID,
  input wire logic [7:0] EXP_RSP_GENERAL,
  input wire logic       IO_CMD_VALID,
  input wire logic       IO_CMD_BAD,
  input wire logic       IO_RSP_SEND,
  input wire logic [7:0] IO_MODE_STATUS,
  input wire logic       IO_CMD_ACCEPT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Command then a response send with no other command between them
  sequence s_bad_send;
    IO_CMD_VALID && IO_CMD_BAD ##1 IO_RSP_SEND && !IO_CMD_VALID;
  endsequence
  sequence s_good_send;
    IO_CMD_VALID && !IO_CMD_BAD ##1 IO_RSP_SEND && !IO_CMD_VALID;
  endsequence
  property p_rsp_next; EXP_REQ_VALID |=> EXP_RSP_VALID; endproperty
  property p_rsp_only; !EXP_REQ_VALID |=> !EXP_RSP_VALID; endproperty
  property p_seg; EXP_REQ_VALID && EXP_PATH_SEG_BAD |=> EXP_RSP_GENERAL == GEN_PATH_SEGMENT;
  endproperty
  property p_unknown;
    EXP_REQ_VALID && !EXP_PATH_SEG_BAD && EXP_PATH_UNKNOWN |=> EXP_RSP_GENERAL == GEN_PATH_UNKNOWN;
  endproperty
  property p_no_old; EXP_RSP_VALID |-> EXP_RSP_GENERAL != GEN_BAD_PARAM_OLD; endproperty
  property p_flag_set; s_bad_send |=> IO_MODE_STATUS[MODE_ERR_BIT]; endproperty
  property p_flag_clr; s_good_send |=> !IO_MODE_STATUS[MODE_ERR_BIT]; endproperty
  property p_hold; !IO_RSP_SEND |=> $stable(IO_MODE_STATUS); endproperty
  property p_accept; IO_CMD_VALID && !IO_CMD_BAD |=> IO_CMD_ACCEPT; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no response after request");
  a_rsp_only: assert property (p_rsp_only) else $error("response without request");
  a_seg: assert property (p_seg) else $error("path segment code wrong");
  a_unknown: assert property (p_unknown) else $error("unknown path code wrong");
  a_no_old: assert property (p_no_old) else $error("old parameter code returned");
  a_flag_set: assert property (p_flag_set) else $error("mode error flag not set");
  a_flag_clr: assert property (p_flag_clr) else $error("mode error flag not cleared");
  a_hold: assert property (p_hold) else $error("mode status moved without send");
  a_accept: assert property (p_accept) else $error("good command not accepted");
endmodule : fer_chk
bind fer_responder fer_chk i_chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .EXP_REQ_VALID(EXP_REQ_VALID), .EXP_PATH_SEG_BAD(EXP_PATH_SEG_BAD),
  .EXP_PATH_UNKNOWN(EXP_PATH_UNKNOWN), .EXP_RSP_VALID(EXP_RSP_VALID),
  .EXP_RSP_GENERAL(EXP_RSP_GENERAL), .IO_CMD_VALID(IO_CMD_VALID), .IO_CMD_BAD(IO_CMD_BAD),
  .IO_RSP_SEND(IO_RSP_SEND), .IO_MODE_STATUS(IO_MODE_STATUS), .IO_CMD_ACCEPT(IO_CMD_ACCEPT));

// file: fer_code_enc.sv
// Encoder from a fault cause to the general and additional error code bytes
`timescale 1ns/10ps
module fer_code_enc
  import fer_pkg::*;
(
  fer_code_if.enc cif
);
  import fer_pkg::*;

  // Vendor numbers inside the prefix page travel directly, except A3FE; others point to the object
  function automatic logic [7:0] vendor_add(input logic [15:0] num);
    if (num[15:8] == VENDOR_PREFIX && num[7:0] != ADD_SEE_OBJECT)
      vendor_add = num[7:0];
    else
      vendor_add = ADD_SEE_OBJECT;
  endfunction : vendor_add

  // Cause to general code table
  always_comb
  begin
    cif.additional = ADD_NONE;
    case (cif.cause)
      FER_OK:            cif.general = GEN_SUCCESS;        // see (RL7)
      FER_CONN_FAIL:     cif.general = GEN_CONN_FAILURE;   // see (RL8)
      FER_NO_RESOURCE:   cif.general = GEN_RESOURCE;       // see (RL9)
      FER_BAD_PARAM:     cif.general = GEN_BAD_PARAM;      // see (RL10)
      FER_PATH_SEGMENT:  cif.general = GEN_PATH_SEGMENT;   // see (RL11)
      FER_PATH_UNKNOWN:  cif.general = GEN_PATH_UNKNOWN;   // see (RL12)
      FER_PARTIAL:       cif.general = GEN_PARTIAL;        // see (RL13)
      FER_CONN_LOST:     cif.general = GEN_CONN_LOST;      // see (RL14)
      FER_NO_SERVICE:    cif.general = GEN_NO_SERVICE;     // see (RL15)
      FER_BAD_ATTR:      cif.general = GEN_BAD_ATTR_VALUE; // see (RL16)
      FER_ATTR_LIST:     cif.general = GEN_ATTR_LIST;      // see (RL17)
      FER_ALREADY_STATE: cif.general = GEN_ALREADY_STATE;  // see (RL18)
      FER_OBJ_STATE:     cif.general = GEN_OBJ_STATE;      // see (RL18)
      FER_DEV_STATE:     cif.general = GEN_DEV_STATE;      // see (RL18)
      FER_OBJ_EXISTS:    cif.general = GEN_OBJ_EXISTS;     // see (RL19)
      FER_NOT_SETTABLE:  cif.general = GEN_NOT_SETTABLE;   // see (RL20)
      FER_PRIVILEGE:     cif.general = GEN_PRIVILEGE;      // see (RL21)
      FER_REPLY_LARGE:   cif.general = GEN_REPLY_LARGE;    // see (RL22)
      FER_VENDOR:
      begin
        cif.general    = GEN_VENDOR;                       // see (RL2)
        cif.additional = vendor_add(cif.vendor_num);       // see (RL2)
      end
      default:           cif.general = GEN_DEV_STATE;
    endcase
  end

endmodule : fer_code_enc

// file: fer_code_if.sv
// Interface carrying a cause and its two-byte explicit status
`timescale 1ns/10ps
interface fer_code_if;
  import fer_pkg::*;
  fer_cause_e  cause;
  logic [15:0] vendor_num;
  logic [7:0]  general;
  logic [7:0]  additional;
  modport top (output cause, output vendor_num, input general, input additional);
  modport enc (input cause, input vendor_num, output general, output additional);
endinterface : fer_code_if

// file: fer_master_model.sv
// Master side model that rebuilds vendor error numbers from explicit responses
`timescale 1ns/10ps
module fer_master_model
  import fer_pkg::*;
(
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  general,
  input  wire logic [7:0]  additional,
  output logic             need_obj_read,
  output logic [15:0]      vendor_num
);
  // Only a vendor response carries a coded number; anything else leaves both quiet
  always_comb
  begin
    need_obj_read = rsp_valid && general == GEN_VENDOR && additional == ADD_SEE_OBJECT;
    vendor_num    = 16'h0000;
    if (rsp_valid && general == GEN_VENDOR && !need_obj_read)
      vendor_num = {VENDOR_PREFIX, additional};
  end
endmodule : fer_master_model

// file: fer_pkg.sv
// Package with codes, positions and reset values for the fieldbus error responder
package fer_pkg;

  // General error codes of an explicit response
  localparam logic [7:0] GEN_SUCCESS        = 8'h00;
  localparam logic [7:0] GEN_CONN_FAILURE   = 8'h01;
  localparam logic [7:0] GEN_RESOURCE       = 8'h02;
  localparam logic [7:0] GEN_BAD_PARAM_OLD  = 8'h03;
  localparam logic [7:0] GEN_PATH_SEGMENT   = 8'h04;
  localparam logic [7:0] GEN_PATH_UNKNOWN   = 8'h05;
  localparam logic [7:0] GEN_PARTIAL        = 8'h06;
  localparam logic [7:0] GEN_CONN_LOST      = 8'h07;
  localparam logic [7:0] GEN_NO_SERVICE     = 8'h08;
  localparam logic [7:0] GEN_BAD_ATTR_VALUE = 8'h09;
  localparam logic [7:0] GEN_ATTR_LIST      = 8'h0A;
  localparam logic [7:0] GEN_ALREADY_STATE  = 8'h0B;
  localparam logic [7:0] GEN_OBJ_STATE      = 8'h0C;
  localparam logic [7:0] GEN_OBJ_EXISTS     = 8'h0D;
  localparam logic [7:0] GEN_NOT_SETTABLE   = 8'h0E;
  localparam logic [7:0] GEN_PRIVILEGE      = 8'h0F;
  localparam logic [7:0] GEN_DEV_STATE      = 8'h10;
  localparam logic [7:0] GEN_REPLY_LARGE    = 8'h11;
  localparam logic [7:0] GEN_VENDOR         = 8'h1F;
  localparam logic [7:0] GEN_BAD_PARAM      = 8'h20;

  // Additional code handling of vendor errors
  localparam logic [7:0]  ADD_NONE          = 8'h00;
  localparam logic [7:0]  ADD_SEE_OBJECT    = 8'hFE;
  localparam logic [7:0]  VENDOR_PREFIX     = 8'hA3;

  // Last error object address, class.instance.attribute
  localparam logic [15:0] ERR_OBJ_CLASS     = 16'h0064;
  localparam logic [7:0]  ERR_OBJ_INST      = 8'h01;
  localparam logic [7:0]  ERR_OBJ_ATTR      = 8'h01;

  // Mode status byte layout and reset values
  localparam int unsigned MODE_ERR_BIT      = 6;
  localparam logic [7:0]  MODE_STAT_RST     = 8'h00;
  localparam logic [15:0] ERR_NUM_RST       = 16'h0000;

  // Fault causes reported by the request decoder
  typedef enum logic [4:0] {
    FER_OK, FER_CONN_FAIL, FER_NO_RESOURCE, FER_BAD_PARAM, FER_PATH_SEGMENT,
    FER_PATH_UNKNOWN, FER_PARTIAL, FER_CONN_LOST, FER_NO_SERVICE,
    FER_BAD_ATTR, FER_ATTR_LIST, FER_ALREADY_STATE, FER_OBJ_STATE,
    FER_OBJ_EXISTS, FER_NOT_SETTABLE, FER_PRIVILEGE, FER_DEV_STATE,
    FER_REPLY_LARGE, FER_VENDOR
  } fer_cause_e;

endpackage : fer_pkg

// file: fer_responder.sv
// Top of the fieldbus error responder: explicit status and cyclic mode error flag
// Function
// (RL1) A failed explicit request answers with general code then additional code.
// (RL2) General code 1F carries a coded vendor error number in the additional byte.
// (RL3) Latest error number is readable through explicit access to object 100.1.1.
// (RL4) Invalid cyclic command sets bit 6 of mode status in next response.
// (RL5) Raising the mode error flag never stops the running operation.
// (RL6) Mode error flag clears after the next valid cyclic data transfer.
// (RL7) Successful service returns general code 00.
// (RL8) Connection service failure along the path returns code 01.
// (RL9) Unavailable resources return general code 02.
// (RL10) Invalid parameter value is reported with preferred code 20, not 03.
// (RL11) Uninterpretable path segment aborts path processing and returns 04.
// (RL12) Unknown class, instance or element stops path processing, returns 05.
// (RL13) Partial data transfer returns general code 06.
// (RL14) Interrupted messaging connection returns general code 07.
// (RL15) Unsupported or undefined service returns general code 08.
// (RL16) Invalid attribute data returns general code 09.
// (RL17) Nonzero status inside attribute list operation returns code 0A.
// (RL18) State conflicts: 0B already in state, 0C object, 10 device.
// (RL19) Creating an existing instance returns general code 0D.
// (RL20) Writing a non-settable attribute returns general code 0E.
// (RL21) Failed privilege check returns general code 0F.
// (RL22) Reply exceeding response buffer returns general code 11.
// (RL23) Master reads object 100.1.1 when the additional code is FE.
// (RL24) Master prefixes A3 to any other additional code for the number.
`timescale 1ns/10ps
module fer_responder
  import fer_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // Explicit request, already parsed by the message layer
  input  wire logic        EXP_REQ_VALID,
  input  wire logic        EXP_PATH_SEG_BAD,
  input  wire logic        EXP_PATH_UNKNOWN,
  input  wire logic        EXP_CONN_FAIL,
  input  wire logic        EXP_CONN_LOST,
  input  wire logic        EXP_NO_SERVICE,
  input  wire logic        EXP_PRIVILEGE_FAIL,
  input  wire logic        EXP_NO_RESOURCE,
  input  wire logic        EXP_DEV_STATE_BAD,
  input  wire logic        EXP_OBJ_STATE_BAD,
  input  wire logic        EXP_ALREADY_STATE,
  input  wire logic        EXP_OBJ_EXISTS,
  input  wire logic        EXP_NOT_SETTABLE,
  input  wire logic        EXP_BAD_PARAM,
  input  wire logic        EXP_BAD_ATTR,
  input  wire logic        EXP_ATTR_LIST_BAD,
  input  wire logic        EXP_PARTIAL,
  input  wire logic        EXP_REPLY_LARGE,
  input  wire logic        EXP_READ_ERR_OBJ,
  input  wire logic [15:0] EXP_CLASS,
  input  wire logic [7:0]  EXP_INSTANCE,
  input  wire logic [7:0]  EXP_ATTRIBUTE,
  // Vendor fault raised by the drive application
  input  wire logic        VENDOR_ERR_VALID,
  input  wire logic [15:0] VENDOR_ERR_NUM,
  // Explicit response
  output logic             EXP_RSP_VALID,
  output logic [7:0]       EXP_RSP_GENERAL,
  output logic [7:0]       EXP_RSP_ADDITIONAL,
  output logic             EXP_RSP_DATA_VALID,
  output logic [15:0]      EXP_RSP_ERR_NUM,
  // Cyclic I/O
  input  wire logic        IO_CMD_VALID,
  input  wire logic        IO_CMD_BAD,
  input  wire logic        IO_RSP_SEND,
  input  wire logic [7:0]  IO_STATUS_IN,
  output logic [7:0]       IO_MODE_STATUS,
  output logic             IO_CMD_ACCEPT,
  output logic [15:0]      LAST_ERR_NUM
);
  import fer_pkg::*;

  fer_code_if  cif ();
  fer_cause_e  cause;
  logic        vendor_pending;
  logic [15:0] vendor_num;
  logic        mode_error_flag;
  logic        err_obj_hit;
  logic [15:0] last_err;

  // Object 100.1.1 address match
  assign err_obj_hit = EXP_READ_ERR_OBJ && EXP_CLASS == ERR_OBJ_CLASS &&
                       EXP_INSTANCE == ERR_OBJ_INST && EXP_ATTRIBUTE == ERR_OBJ_ATTR;

  // Priority follows processing order: path first, since path errors abort decoding
  always_comb
  begin
    if (EXP_PATH_SEG_BAD)
      cause = FER_PATH_SEGMENT;                         // see (RL11)
    else if (EXP_PATH_UNKNOWN)
      cause = FER_PATH_UNKNOWN;                         // see (RL12)
    else if (EXP_CONN_FAIL)
      cause = FER_CONN_FAIL;                            // see (RL8)
    else if (EXP_CONN_LOST)
      cause = FER_CONN_LOST;                            // see (RL14)
    else if (EXP_NO_SERVICE)
      cause = FER_NO_SERVICE;                           // see (RL15)
    else if (EXP_PRIVILEGE_FAIL)
      cause = FER_PRIVILEGE;                            // see (RL21)
    else if (EXP_NO_RESOURCE)
      cause = FER_NO_RESOURCE;                          // see (RL9)
    else if (EXP_DEV_STATE_BAD)
      cause = FER_DEV_STATE;                            // see (RL18)
    else if (EXP_OBJ_STATE_BAD)
      cause = FER_OBJ_STATE;                            // see (RL18)
    else if (EXP_ALREADY_STATE)
      cause = FER_ALREADY_STATE;                        // see (RL18)
    else if (EXP_OBJ_EXISTS)
      cause = FER_OBJ_EXISTS;                           // see (RL19)
    else if (EXP_NOT_SETTABLE)
      cause = FER_NOT_SETTABLE;                         // see (RL20)
    else if (EXP_BAD_PARAM)
      cause = FER_BAD_PARAM;                            // see (RL10)
    else if (EXP_BAD_ATTR)
      cause = FER_BAD_ATTR;                             // see (RL16)
    else if (EXP_ATTR_LIST_BAD)
      cause = FER_ATTR_LIST;                            // see (RL17)
    else if (EXP_PARTIAL)
      cause = FER_PARTIAL;                              // see (RL13)
    else if (EXP_REPLY_LARGE)
      cause = FER_REPLY_LARGE;                          // see (RL22)
    else if (vendor_pending)
      cause = FER_VENDOR;                               // see (RL2)
    else
      cause = FER_OK;                                   // see (RL7)
  end

  assign cif.cause      = cause;
  assign cif.vendor_num = vendor_num;

  fer_code_enc u_enc (
    .cif (cif)
  );

  // Vendor fault waits for the next explicit request with no other fault; a new fault wins over consumption
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      vendor_pending <= 1'b0;
      vendor_num     <= ERR_NUM_RST;
    end
    else if (VENDOR_ERR_VALID)
    begin
      vendor_pending <= 1'b1;
      vendor_num     <= VENDOR_ERR_NUM;
    end
    else if (EXP_REQ_VALID && cause == FER_VENDOR)
      vendor_pending <= 1'b0;
  end

  // Most recent error number, kept for explicit reads of the error object
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      last_err <= ERR_NUM_RST;
    else if (VENDOR_ERR_VALID)
      last_err <= VENDOR_ERR_NUM;                       // see (RL3)
    else if (EXP_REQ_VALID && cause != FER_OK && cause != FER_VENDOR)
      last_err <= {8'h00, cif.general};                 // see (RL3)
  end

  // Explicit response registers: one-cycle answer a clock after the request
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      EXP_RSP_VALID      <= 1'b0;
      EXP_RSP_GENERAL    <= GEN_SUCCESS;
      EXP_RSP_ADDITIONAL <= ADD_NONE;
      EXP_RSP_DATA_VALID <= 1'b0;
      EXP_RSP_ERR_NUM    <= ERR_NUM_RST;
    end
    else
    begin
      EXP_RSP_VALID      <= EXP_REQ_VALID;
      EXP_RSP_GENERAL    <= cif.general;                // see (RL1)
      EXP_RSP_ADDITIONAL <= cif.additional;             // see (RL1)
      // Error object read is served only when the request itself has no fault
      EXP_RSP_DATA_VALID <= EXP_REQ_VALID && err_obj_hit && cause == FER_OK;  // see (RL3)
      EXP_RSP_ERR_NUM    <= last_err;                   // see (RL3)
    end
  end

  // Mode error flag: set by a bad cyclic command, cleared by the next valid one
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      mode_error_flag <= 1'b0;
    else if (IO_CMD_VALID && IO_CMD_BAD)
      mode_error_flag <= 1'b1;                          // see (RL4)
    else if (IO_CMD_VALID)
      mode_error_flag <= 1'b0;                          // see (RL6)
  end

  // Valid commands pass on; a bad one is dropped but nothing running is halted
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      IO_CMD_ACCEPT <= 1'b0;
    else
      IO_CMD_ACCEPT <= IO_CMD_VALID && !IO_CMD_BAD;     // see (RL5)
  end

  // Mode status byte latched when the response goes out
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      IO_MODE_STATUS <= MODE_STAT_RST;
    else if (IO_RSP_SEND)
    begin
      IO_MODE_STATUS               <= IO_STATUS_IN;
      IO_MODE_STATUS[MODE_ERR_BIT] <= mode_error_flag;  // see (RL4)
    end
  end

  // Last error number mirrored out one cycle late, so the pin comes straight from a flop
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      LAST_ERR_NUM <= ERR_NUM_RST;
    else
      LAST_ERR_NUM <= last_err;                         // see (RL3)
  end

endmodule : fer_responder

// file: testbench.sv
// Self-checking bench for the fieldbus error responder
`timescale 1ns/10ps
module testbench;
  import fer_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        rd = 1'b0;
  logic [16:0] flt = 17'h00000;
  logic        ven = 1'b0;
  logic [15:0] ven_num = 16'h0000;
  logic [15:0] cls = 16'h0064;
  logic        io_vld = 1'b0;
  logic        io_bad = 1'b0;
  logic        io_send = 1'b0;
  logic [7:0]  io_in = 8'h00;
  logic        rsp, dv, acc, need;
  logic [7:0]  gen, add, mode;
  logic [15:0] err, last, vnum;
  int          n_fail = 0;
  int          checks_done = 0;
  // Expected code for each fault flag, highest priority first
  logic [7:0]  codes [17] = '{8'h04, 8'h05, 8'h01, 8'h07, 8'h08, 8'h0F, 8'h02, 8'h10, 8'h0C,
                             8'h0B, 8'h0D, 8'h0E, 8'h20, 8'h09, 8'h0A, 8'h06, 8'h11};
  always #2.5 clk = ~clk;
  // Class follows cls so a read can miss the error object; instance and attribute stay on it
  fer_responder i_dut (.REF_CLK(clk), .RESETN(rst_n), .EXP_REQ_VALID(req),
    .EXP_PATH_SEG_BAD(flt[0]), .EXP_PATH_UNKNOWN(flt[1]), .EXP_CONN_FAIL(flt[2]),
    .EXP_CONN_LOST(flt[3]), .EXP_NO_SERVICE(flt[4]), .EXP_PRIVILEGE_FAIL(flt[5]),
    .EXP_NO_RESOURCE(flt[6]), .EXP_DEV_STATE_BAD(flt[7]), .EXP_OBJ_STATE_BAD(flt[8]),
    .EXP_ALREADY_STATE(flt[9]), .EXP_OBJ_EXISTS(flt[10]), .EXP_NOT_SETTABLE(flt[11]),
    .EXP_BAD_PARAM(flt[12]), .EXP_BAD_ATTR(flt[13]), .EXP_ATTR_LIST_BAD(flt[14]),
    .EXP_PARTIAL(flt[15]), .EXP_REPLY_LARGE(flt[16]), .EXP_READ_ERR_OBJ(rd),
    .EXP_CLASS(cls), .EXP_INSTANCE(8'h01), .EXP_ATTRIBUTE(8'h01), .VENDOR_ERR_VALID(ven),
    .VENDOR_ERR_NUM(ven_num), .EXP_RSP_VALID(rsp), .EXP_RSP_GENERAL(gen),
    .EXP_RSP_ADDITIONAL(add), .EXP_RSP_DATA_VALID(dv), .EXP_RSP_ERR_NUM(err),
    .IO_CMD_VALID(io_vld), .IO_CMD_BAD(io_bad), .IO_RSP_SEND(io_send), .IO_STATUS_IN(io_in),
    .IO_MODE_STATUS(mode), .IO_CMD_ACCEPT(acc), .LAST_ERR_NUM(last));
  fer_master_model i_master (.rsp_valid(rsp), .general(gen), .additional(add),
    .need_obj_read(need), .vendor_num(vnum));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One explicit request, answer judged in the cycle it stands
  task automatic xreq(input logic [16:0] f, input logic r, input logic [7:0] g,
                      input logic [7:0] a);
    @(posedge clk);
    req <= 1'b1;
    flt <= f;
    rd  <= r;
    @(posedge clk);
    req <= 1'b0;
    flt <= 17'h00000;
    rd  <= 1'b0;
    #1;
    chk("rsp_valid", 16'h0001, {15'h0000, rsp});
    chk("general", {8'h00, g}, {8'h00, gen});
    chk("additional", {8'h00, a}, {8'h00, add});
  endtask : xreq
  // Vendor fault pulse, kept pending until the next clean request
  task automatic vpulse(input logic [15:0] n);
    @(posedge clk);
    ven     <= 1'b1;
    ven_num <= n;
    @(posedge clk);
    ven <= 1'b0;
  endtask : vpulse
  // Every fault with all lower ones also raised, so priority shows too
  task automatic t_codes;
    xreq(17'h00000, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 17; i++)
      xreq(17'h1FFFF << i, 1'b0, codes[i], 8'h00);
    @(posedge clk); // Codes above also
    #1;
    chk("last_err", 16'h0011, last);
  endtask : t_codes
  task automatic t_vendor;
    vpulse(16'hA308);
    xreq(17'h00000, 1'b0, 8'h1F, 8'h08);
    chk("vendor_num", 16'hA308, vnum);
    vpulse(16'hA3FE);
    xreq(17'h00000, 1'b0, 8'h1F, 8'hFE);
    chk("need_read", 16'h0001, {15'h0000, need});
    vpulse(16'h1234);
    xreq(17'h00000, 1'b0, 8'h1F, 8'hFE);
    chk("need_read", 16'h0001, {15'h0000, need});
    xreq(17'h00000, 1'b1, 8'h00, 8'h00);
    chk("data_valid", 16'h0001, {15'h0000, dv});
    chk("err_num", 16'h1234, err);
    // A read of another class must not be served as the error object
    @(posedge clk);
    cls <= 16'h0065;
    xreq(17'h00000, 1'b1, 8'h00, 8'h00);
    chk("data_valid", 16'h0000, {15'h0000, dv});
    @(posedge clk);
    cls <= 16'h0064;
  endtask : t_vendor
  // Bad command flags the next response; a good one still passes and clears it
  task automatic t_io;
    @(posedge clk);
    io_vld <= 1'b1;
    io_bad <= 1'b1;
    @(posedge clk);
    io_vld  <= 1'b0;
    io_bad  <= 1'b0;
    io_send <= 1'b1;
    io_in   <= 8'hA5;
    @(posedge clk);
    io_send <= 1'b0;
    io_vld  <= 1'b1;
    #1;
    chk("mode_status", 16'h00E5, {8'h00, mode});
    @(posedge clk);
    io_vld  <= 1'b0;
    io_send <= 1'b1;
    io_in   <= 8'h5A;
    #1;
    chk("cmd_accept", 16'h0001, {15'h0000, acc});
    @(posedge clk);
    io_send <= 1'b0;
    #1;
    chk("mode_status", 16'h001A, {8'h00, mode});
  endtask : t_io
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_codes();
    t_vendor();
    t_io();
    complete_run();
  end
  // Watchdog: the sequence needs 63 cycles, so 2000 means a hang
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : testbench
